// *** design/age_tick_gen.sv ***
`timescale 1ns/1ps
`default_nettype none
module age_tick_gen (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic [15:0] interval_i,
  output logic [1:0] age_gray_o,
  output logic [4:0] phase_o
);
  import line_buffer_pkg::*;
  logic [15:0] cnt_reg; // cycles within the current age window
  logic [15:0] sub_reg; // cycles within the current phase slot
  logic [1:0] bin_reg; // binary age, shown gray coded
  logic [15:0] last; // interval minus one, zero treated as one
  logic [15:0] step; // phase slot length, at least one
  logic tick;
  assign last = (interval_i == 16'h0000) ? 16'h0000 : interval_i - 16'h0001;
  assign step = ((interval_i >> PHASE_SHIFT) == 16'h0000) ? 16'h0001 :
                (interval_i >> PHASE_SHIFT);
  assign tick = (cnt_reg >= last);
  assign age_gray_o = {bin_reg[1], bin_reg[1] ^ bin_reg[0]};
  // window counter and age advance every interval cycles
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      cnt_reg <= 16'h0000;
      bin_reg <= 2'h0;
    end else if (tick) begin
      cnt_reg <= 16'h0000;
      bin_reg <= bin_reg + 2'h1;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end
  // phase slots spread line age-outs across the window
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || tick) begin
      sub_reg <= 16'h0000;
      phase_o <= 5'h00;
    end else if (sub_reg >= step - 16'h0001) begin
      sub_reg <= 16'h0000;
      if (phase_o != 5'h1F) begin
        phase_o <= phase_o + 5'h01;
      end
    end else begin
      sub_reg <= sub_reg + 16'h0001;
    end
  end
endmodule // age_tick_gen
`default_nettype wire

// *** design/data_line_buffer_bridge.sv ***
// Overview of operation
// - up to 32 lines of four 32-bit words
// - only window 0x10060000-0x1FFFFFFF is buffered
// - tcm, nvm and fetches bypass the lines
// - zero-line bypass passes accesses straight through
// - five line states, invalid reused first
// - modified line written back before reuse
// - write miss buffers bytes, read reloads and merges
// - fully written write line becomes modified
// - read miss fills a shared line
// - write to shared line makes it modified
// - pick lowest invalid, then lowest lru shared
// - reset invalidates all lines and writes
// - free-line target from level and line count
// - flush dirty line when free below target
// - flush: modified to shared, write to invalid
// - gray age counter steps every n cycles
// - stamp on access, age out at plus two
// - aged shared invalidates, aged dirty flushes
// - lines live one to three age intervals
// - flush on demand when allocation stalls
// - age-out delayed by line-proportional phase
// - discard bit invalidates all shared lines
// - drain bit flushes all dirty lines within the enabled line count
// - drain status low while drain runs
// - four recency groups per line
`timescale 1ns/1ps
`default_nettype none
module data_line_buffer_bridge #(
  parameter int NUM_LINES = 32
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic cpu_req_i,
  input wire logic cpu_we_i,
  input wire logic cpu_instr_i,
  input wire logic [31:0] cpu_addr_i,
  input wire logic [31:0] cpu_wdata_i,
  input wire logic [3:0] cpu_be_i,
  output logic cpu_ready_o,
  output logic [31:0] cpu_rdata_o,
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [31:0] mem_addr_o,
  output logic [line_buffer_pkg::LINE_BITS-1:0] mem_wdata_o,
  output logic [line_buffer_pkg::LINE_BYTES-1:0] mem_wstrb_o,
  input wire logic mem_ack_i,
  input wire logic [line_buffer_pkg::LINE_BITS-1:0] mem_rdata_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [31:0] reg_rdata_o
);
  import line_buffer_pkg::*;
  localparam int IW = $clog2(NUM_LINES);

  // two-bit gray to binary
  function automatic logic [1:0] gray2bin(input logic [1:0] g);
    return {g[1], g[1] ^ g[0]};
  endfunction
  // byte enables to a bit mask
  function automatic logic [LINE_BITS-1:0] expand_be(
      input logic [LINE_BYTES-1:0] be);
    logic [LINE_BITS-1:0] m;
    m = '0;
    for (int b = 0; b < LINE_BYTES; b++) begin
      m[b*8 +: 8] = {8{be[b]}};
    end
    return m;
  endfunction

  // software settings
  logic bypass_reg; // zero_line_bypass
  logic level_reg; // preemptive_flush_threshold
  logic [5:0] lines_reg; // enabled line count
  logic [15:0] age_interval_reg; // age_tick_interval
  logic drain_busy_reg; // inverse of drain_complete_flag
  // line table
  line_state_t st_reg [NUM_LINES];
  logic [TAG_BITS-1:0] tag_reg [NUM_LINES];
  logic [LINE_BITS-1:0] data_reg [NUM_LINES];
  logic [LINE_BYTES-1:0] be_reg [NUM_LINES];
  logic [1:0] stamp_reg [NUM_LINES];
  logic [1:0] grp_reg [NUM_LINES];
  // controller
  ctl_state_t ctl_reg;
  logic [IW-1:0] busy_idx_reg; // line under fill or flush
  logic [1:0] age_gray;
  logic [4:0] phase;
  // per-line masks and derived terms
  logic [NUM_LINES-1:0] en_mask, hit_mask, inv_mask, sh_lru_mask;
  logic [NUM_LINES-1:0] dirty_mask, dirty_lru_mask, aged_mask, fl_mask;
  logic [NUM_LINES-1:0] pref_dirty;
  logic [5:0] free_cnt, target, mru_cnt, lru_cnt, mru_limit;
  logic hit_found, inv_found, sh_found, fl_found;
  logic [IW-1:0] hit_idx, inv_idx, sh_idx, fl_idx, vic_idx;
  logic cached, stall_need, preempt, demote;
  logic [1:0] ins_grp;
  logic [TAG_BITS-1:0] cpu_tag;
  logic [1:0] cpu_word;
  logic ctrl_wr;

  assign cpu_tag = cpu_addr_i[31:4];
  assign cpu_word = cpu_addr_i[3:2];
  assign ctrl_wr = reg_we_i && (reg_addr_i == REG_CTRL);
  assign cpu_ready_o = (ctl_reg == ST_DONE);
  // only data accesses in the window, with lines enabled, are buffered
  assign cached = (cpu_addr_i >= WIN_LO) && (cpu_addr_i <= WIN_HI) &&
                  !cpu_instr_i &&
                  !bypass_reg && (lines_reg != 6'h00);

  // line classification, all lines compared in one cycle
  always_comb begin
    for (int i = 0; i < NUM_LINES; i++) begin
      en_mask[i] = (i < int'(lines_reg));
      hit_mask[i] = en_mask[i] && (st_reg[i] != LN_INVALID) &&
                    (tag_reg[i] == cpu_tag);
      inv_mask[i] = en_mask[i] && (st_reg[i] == LN_INVALID);
      sh_lru_mask[i] = en_mask[i] && (st_reg[i] == LN_SHARED) &&
                       (grp_reg[i] == GRP_LRU);
      dirty_mask[i] = en_mask[i] && ((st_reg[i] == LN_MODIFIED) ||
                      (st_reg[i] == LN_WRITE));
      dirty_lru_mask[i] = dirty_mask[i] && (grp_reg[i] == GRP_LRU);
      // age-out at stamp plus two or later, after this line's phase slot
      aged_mask[i] = en_mask[i] && (st_reg[i] != LN_INVALID) &&
                     ((gray2bin(age_gray) - gray2bin(stamp_reg[i])) >=
                      AGE_OUT_DIST) &&
                     (int'(phase) >= (i % MAX_LINES));
    end
  end

  // free lines, recency populations and targets
  always_comb begin
    free_cnt = 6'h00;
    mru_cnt = 6'h00;
    lru_cnt = 6'h00;
    for (int i = 0; i < NUM_LINES; i++) begin
      // invalid, shared or under flush counts as free
      if (inv_mask[i] || (en_mask[i] && st_reg[i] == LN_SHARED) ||
          (ctl_reg == ST_FLUSH && busy_idx_reg == IW'(i))) begin
        free_cnt = free_cnt + 6'h01;
      end
      if (en_mask[i] && grp_reg[i] == GRP_MRU) begin
        mru_cnt = mru_cnt + 6'h01;
      end
      if (en_mask[i] && grp_reg[i] == GRP_LRU) begin
        lru_cnt = lru_cnt + 6'h01;
      end
    end
    // free target by line count and level
    if (lines_reg >= 6'h03) begin
      target = level_reg ? 6'h03 : 6'h02;
    end else if (lines_reg == 6'h02) begin
      target = level_reg ? 6'h02 : 6'h01;
    end else begin
      target = 6'h00;
    end
    // newly touched line group for small configurations
    if (lines_reg == 6'h01) begin
      ins_grp = GRP_LRU;
    end else if (lines_reg == 6'h02) begin
      ins_grp = GRP_2ND;
    end else if (lines_reg == 6'h03) begin
      ins_grp = GRP_3RD;
    end else begin
      ins_grp = GRP_MRU;
    end
    mru_limit = ((lines_reg >> 2) == 6'h00) ? 6'h01 : (lines_reg >> 2);
    demote = (mru_cnt >= mru_limit) || (lru_cnt == 6'h00);
  end

  // flush candidate: drain first, then stall, aging, preemptive
  always_comb begin
    pref_dirty = (dirty_lru_mask != '0) ? dirty_lru_mask : dirty_mask;
    stall_need = cpu_req_i && cached && !hit_found && !inv_found &&
                 !sh_found;
    preempt = (free_cnt < target) && (lines_reg >= 6'h02);
    if (drain_busy_reg) begin
      fl_mask = dirty_mask;
    end else if (stall_need) begin
      fl_mask = pref_dirty;
    end else if ((aged_mask & dirty_mask) != '0) begin
      fl_mask = aged_mask & dirty_mask;
    end else if (preempt) begin
      fl_mask = pref_dirty;
    end else begin
      fl_mask = '0;
    end
    vic_idx = inv_found ? inv_idx : sh_idx;
  end

  lowest_set_picker #(.N(NUM_LINES), .IW(IW)) hit_pick (
    .mask_i(hit_mask), .found_o(hit_found), .idx_o(hit_idx));
  lowest_set_picker #(.N(NUM_LINES), .IW(IW)) inv_pick (
    .mask_i(inv_mask), .found_o(inv_found), .idx_o(inv_idx));
  lowest_set_picker #(.N(NUM_LINES), .IW(IW)) sh_pick (
    .mask_i(sh_lru_mask), .found_o(sh_found), .idx_o(sh_idx));
  lowest_set_picker #(.N(NUM_LINES), .IW(IW)) fl_pick (
    .mask_i(fl_mask), .found_o(fl_found), .idx_o(fl_idx));

  age_tick_gen ager (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .interval_i(age_interval_reg),
    .age_gray_o(age_gray),
    .phase_o(phase)
  );

  // software registers, discard and drain bits are write-one pulses
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      bypass_reg <= 1'b0;
      level_reg <= 1'b0;
      lines_reg <= RESET_LINES;
      age_interval_reg <= RESET_AGE_INTERVAL;
    end else if (reg_we_i) begin
      if (reg_addr_i == REG_CTRL) begin
        bypass_reg <= reg_wdata_i[CTRL_BYPASS_BIT];
        level_reg <= reg_wdata_i[CTRL_LEVEL_BIT];
      end
      if (reg_addr_i == REG_CFG) begin
        lines_reg <= (reg_wdata_i[CFG_LINES_LSB +: 6] > 6'(NUM_LINES)) ?
                     6'(NUM_LINES) : reg_wdata_i[CFG_LINES_LSB +: 6];
        age_interval_reg <= reg_wdata_i[CFG_AGE_LSB +: 16];
      end
    end
  end

  // register read data, one cycle after the strobe
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_re_i) begin
      reg_rdata_o <= 32'h0000_0000;
      case (reg_addr_i)
        REG_CTRL: begin
          reg_rdata_o[CTRL_BYPASS_BIT] <= bypass_reg;
          reg_rdata_o[CTRL_LEVEL_BIT] <= level_reg;
        end
        REG_CFG: begin
          reg_rdata_o[CFG_LINES_LSB +: 6] <= lines_reg;
          reg_rdata_o[CFG_AGE_LSB +: 16] <= age_interval_reg;
        end
        REG_STATUS: begin
          reg_rdata_o[STAT_DRAIN_DONE_BIT] <= !drain_busy_reg;
          reg_rdata_o[STAT_FREE_LSB +: 6] <= free_cnt;
        end
        default: begin
          reg_rdata_o <= 32'h0000_0000; // unmapped reads as zero
        end
      endcase
    end
  end

  // drain status: a new request wins over completion in the same cycle
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      drain_busy_reg <= 1'b0;
    end else if (ctrl_wr && reg_wdata_i[CTRL_DRAIN_BIT]) begin
      drain_busy_reg <= 1'b1;
    end else if (dirty_mask == '0 && ctl_reg != ST_FLUSH) begin
      drain_busy_reg <= 1'b0;
    end
  end

  // controller, memory port and line table
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      ctl_reg <= ST_IDLE;
      busy_idx_reg <= '0;
      cpu_rdata_o <= 32'h0000_0000;
      mem_req_o <= 1'b0;
      mem_we_o <= 1'b0;
      mem_addr_o <= 32'h0000_0000;
      mem_wdata_o <= '0;
      mem_wstrb_o <= '0;
      for (int i = 0; i < NUM_LINES; i++) begin
        st_reg[i] <= LN_INVALID;
        be_reg[i] <= '0;
        tag_reg[i] <= '0;
        data_reg[i] <= '0;
        stamp_reg[i] <= 2'h0;
        grp_reg[i] <= GRP_LRU;
      end
    end else begin
      // background invalidation of clean lines
      for (int i = 0; i < NUM_LINES; i++) begin
        if (st_reg[i] == LN_SHARED && aged_mask[i]) begin
          st_reg[i] <= LN_INVALID;
        end
        if (st_reg[i] == LN_SHARED && ctrl_wr &&
            reg_wdata_i[CTRL_DISCARD_BIT]) begin
          st_reg[i] <= LN_INVALID;
        end
      end
      case (ctl_reg)
        ST_IDLE: begin
          if (cpu_req_i && !cached) begin
            // single word straight to memory
            mem_req_o <= 1'b1;
            mem_we_o <= cpu_we_i;
            mem_addr_o <= cpu_addr_i;
            mem_wdata_o <= {4{cpu_wdata_i}};
            mem_wstrb_o <= cpu_we_i ?
                           ({12'h000, cpu_be_i} << {cpu_word, 2'b00}) : '0;
            ctl_reg <= ST_BYP;
          end else if (cpu_req_i && (hit_found || inv_found || sh_found)) begin
            busy_idx_reg <= hit_found ? hit_idx : vic_idx;
            // touch: stamp age and move to the newest group
            for (int i = 0; i < NUM_LINES; i++) begin
              if (demote && grp_reg[i] != GRP_LRU) begin
                grp_reg[i] <= grp_reg[i] + 2'h1;
              end
            end
            if (hit_found) begin
              stamp_reg[hit_idx] <= age_gray;
              grp_reg[hit_idx] <= ins_grp;
              if (cpu_we_i) begin
                for (int b = 0; b < 4; b++) begin
                  if (cpu_be_i[b]) begin
                    data_reg[hit_idx][cpu_word*32 + b*8 +: 8] <=
                      cpu_wdata_i[b*8 +: 8];
                  end
                end
                be_reg[hit_idx] <= be_reg[hit_idx] |
                  ({12'h000, cpu_be_i} << {cpu_word, 2'b00});
                if (st_reg[hit_idx] == LN_SHARED) begin
                  st_reg[hit_idx] <= LN_MODIFIED;
                end else if (st_reg[hit_idx] == LN_WRITE &&
                    (be_reg[hit_idx] |
                     ({12'h000, cpu_be_i} << {cpu_word, 2'b00})) == '1) begin
                  st_reg[hit_idx] <= LN_MODIFIED;
                end
                ctl_reg <= ST_DONE;
              end else if (st_reg[hit_idx] == LN_WRITE) begin
                // read of a write-only line reloads the rest
                st_reg[hit_idx] <= LN_WRITE_RELOAD;
                mem_req_o <= 1'b1;
                mem_we_o <= 1'b0;
                mem_addr_o <= {cpu_tag, 4'h0};
                mem_wstrb_o <= '0;
                ctl_reg <= ST_FILL;
              end else begin
                cpu_rdata_o <= data_reg[hit_idx][{cpu_word, 5'h00} +: 32];
                ctl_reg <= ST_DONE;
              end
            end else begin
              // allocate the chosen victim, which is never dirty
              tag_reg[vic_idx] <= cpu_tag;
              stamp_reg[vic_idx] <= age_gray;
              grp_reg[vic_idx] <= ins_grp;
              if (cpu_we_i) begin
                for (int b = 0; b < 4; b++) begin
                  data_reg[vic_idx][cpu_word*32 + b*8 +: 8] <=
                    cpu_wdata_i[b*8 +: 8];
                end
                be_reg[vic_idx] <= {12'h000, cpu_be_i} << {cpu_word, 2'b00};
                st_reg[vic_idx] <= LN_WRITE;
                ctl_reg <= ST_DONE;
              end else begin
                st_reg[vic_idx] <= LN_INVALID; // held until the fill lands
                be_reg[vic_idx] <= '0;
                mem_req_o <= 1'b1;
                mem_we_o <= 1'b0;
                mem_addr_o <= {cpu_tag, 4'h0};
                mem_wstrb_o <= '0;
                ctl_reg <= ST_FILL;
              end
            end
          end else if (fl_found) begin
            // write back dirty bytes of the picked line
            busy_idx_reg <= fl_idx;
            mem_req_o <= 1'b1;
            mem_we_o <= 1'b1;
            mem_addr_o <= {tag_reg[fl_idx], 4'h0};
            mem_wdata_o <= data_reg[fl_idx];
            mem_wstrb_o <= be_reg[fl_idx];
            ctl_reg <= ST_FLUSH;
          end
        end
        ST_FILL: begin
          if (mem_ack_i) begin
            mem_req_o <= 1'b0;
            if (st_reg[busy_idx_reg] == LN_WRITE_RELOAD) begin
              // written bytes stay over the fetched data
              data_reg[busy_idx_reg] <=
                (mem_rdata_i & ~expand_be(be_reg[busy_idx_reg])) |
                (data_reg[busy_idx_reg] & expand_be(be_reg[busy_idx_reg]));
              st_reg[busy_idx_reg] <= LN_MODIFIED;
              cpu_rdata_o <= data_reg[busy_idx_reg][{cpu_word, 5'h00} +: 32];
              if (!be_reg[busy_idx_reg][{cpu_word, 2'b00}]) begin
                cpu_rdata_o <= mem_rdata_i[{cpu_word, 5'h00} +: 32];
              end
            end else begin
              data_reg[busy_idx_reg] <= mem_rdata_i;
              st_reg[busy_idx_reg] <= LN_SHARED;
              cpu_rdata_o <= mem_rdata_i[{cpu_word, 5'h00} +: 32];
            end
            ctl_reg <= ST_DONE;
          end
        end
        ST_FLUSH: begin
          if (mem_ack_i) begin
            mem_req_o <= 1'b0;
            be_reg[busy_idx_reg] <= '0;
            st_reg[busy_idx_reg] <=
              (st_reg[busy_idx_reg] == LN_MODIFIED) ? LN_SHARED :
              LN_INVALID;
            ctl_reg <= ST_IDLE;
          end
        end
        ST_BYP: begin
          if (mem_ack_i) begin
            mem_req_o <= 1'b0;
            cpu_rdata_o <= mem_rdata_i[{cpu_word, 5'h00} +: 32];
            ctl_reg <= ST_DONE;
          end
        end
        ST_DONE: begin
          ctl_reg <= ST_IDLE; // master drops its request here
        end
        default: begin
          ctl_reg <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // data_line_buffer_bridge
`default_nettype wire

// *** design/line_buffer_pkg.sv ***
package line_buffer_pkg;
  // line geometry
  localparam int MAX_LINES = 32;
  localparam int LINE_BITS = 128;
  localparam int LINE_BYTES = 16;
  localparam int TAG_BITS = 28;
  // cached address window
  localparam logic [31:0] WIN_LO = 32'h1006_0000;
  localparam logic [31:0] WIN_HI = 32'h1FFF_FFFF;
  // register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CFG = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  // control bit positions
  localparam int CTRL_DISCARD_BIT = 0;
  localparam int CTRL_DRAIN_BIT = 1;
  localparam int CTRL_BYPASS_BIT = 2;
  localparam int CTRL_LEVEL_BIT = 3;
  // configuration fields
  localparam int CFG_LINES_LSB = 0;
  localparam int CFG_AGE_LSB = 16;
  // status fields
  localparam int STAT_DRAIN_DONE_BIT = 0;
  localparam int STAT_FREE_LSB = 8;
  // reset values
  localparam logic [5:0] RESET_LINES = 6'h20;
  localparam logic [15:0] RESET_AGE_INTERVAL = 16'h0100;
  // recency groups and aging distance
  localparam logic [1:0] GRP_MRU = 2'h0;
  localparam logic [1:0] GRP_3RD = 2'h1;
  localparam logic [1:0] GRP_2ND = 2'h2;
  localparam logic [1:0] GRP_LRU = 2'h3;
  localparam logic [1:0] AGE_OUT_DIST = 2'h2;
  localparam int PHASE_SHIFT = 5;
  // per-line states
  typedef enum logic [2:0] {
    LN_INVALID, LN_SHARED, LN_MODIFIED, LN_WRITE, LN_WRITE_RELOAD
  } line_state_t;
  // controller states
  typedef enum logic [2:0] {
    ST_IDLE, ST_FILL, ST_FLUSH, ST_BYP, ST_DONE
  } ctl_state_t;
endpackage

// *** design/lowest_set_picker.sv ***
`timescale 1ns/1ps
`default_nettype none
module lowest_set_picker #(
  parameter int N = 32,
  parameter int IW = 5
) (
  input wire logic [N-1:0] mask_i,
  output logic found_o,
  output logic [IW-1:0] idx_o
);
  // scan from the top so the lowest set bit wins
  always_comb begin
    found_o = 1'b0;
    idx_o = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (mask_i[i]) begin
        found_o = 1'b1;
        idx_o = IW'(i);
      end
    end
  end
endmodule // lowest_set_picker
`default_nettype wire

// *** testbench/data_line_buffer_bridge_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module data_line_buffer_bridge_bench;
  import line_buffer_pkg::*;
  logic mclk_i = 0, sys_rst_i = 1, cpu_req_i = 0, cpu_we_i = 0;
  logic cpu_instr_i = 0, mem_ack_i, reg_we_i = 0, reg_re_i = 0;
  logic [31:0] cpu_addr_i = 0, cpu_wdata_i = 0, reg_wdata_i = 0;
  logic [3:0] cpu_be_i = 4'hF;
  logic [7:0] reg_addr_i = 0;
  logic cpu_ready_o, mem_req_o, mem_we_o;
  logic [31:0] cpu_rdata_o, mem_addr_o, reg_rdata_o, waddr, q;
  logic [127:0] mem_rdata_i;
  logic [15:0] mem_wstrb_o, wstrb;
  int rd_cnt, wr_cnt, err_count = 0, compares = 0, cycles = 0, n0;
  data_line_buffer_bridge #(.NUM_LINES(32)) data_line_buffer_bridge_inst (
    .mclk_i, .sys_rst_i, .cpu_req_i, .cpu_we_i, .cpu_instr_i, .cpu_addr_i,
    .cpu_wdata_i, .cpu_be_i, .cpu_ready_o, .cpu_rdata_o, .mem_req_o,
    .mem_we_o, .mem_addr_o, .mem_wdata_o(), .mem_wstrb_o, .mem_ack_i,
    .mem_rdata_i, .reg_addr_i, .reg_wdata_i, .reg_we_i, .reg_re_i,
    .reg_rdata_o);
  line_mem_model line_mem_model_inst (.mclk_i, .sys_rst_i,
    .mem_req_i(mem_req_o), .mem_we_i(mem_we_o), .mem_addr_i(mem_addr_o),
    .mem_wstrb_i(mem_wstrb_o), .mem_ack_o(mem_ack_i),
    .mem_rdata_o(mem_rdata_i), .rd_cnt_o(rd_cnt), .wr_cnt_o(wr_cnt),
    .waddr_o(waddr), .wstrb_o(wstrb));
  // 40 MHz clock and a hang guard
  always #12.5 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      wrap_up();
    end
  end
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask
  // one cpu access, held until the ready pulse
  task automatic cpu_op(input logic we, input logic [31:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk_i);
    {cpu_req_i, cpu_we_i, cpu_addr_i, cpu_wdata_i} <= {1'b1, we, a, d};
    do @(posedge mclk_i); while (cpu_ready_o !== 1'b1 && ++n < 300);
    q = cpu_rdata_o;
    cpu_req_i <= 1'b0;
  endtask
  task automatic reg_op(input logic we, input logic [7:0] a,
      input logic [31:0] d);
    @(posedge mclk_i);
    {reg_we_i, reg_re_i, reg_addr_i, reg_wdata_i} <= {we, !we, a, d};
    @(posedge mclk_i);
    {reg_we_i, reg_re_i} <= 2'b00;
    @(posedge mclk_i);
    q = reg_rdata_o;
  endtask
  task automatic t_regs;
    reg_op(0, REG_CFG, 0); chk("cfg", 32'h0100_0020, q);
    reg_op(0, REG_STATUS, 0); chk("status", 32'h0000_2001, q);
    reg_op(0, 8'h0C, 0); chk("unmapped", 32'h0000_0000, q);
  endtask
  task automatic t_read;
    n0 = rd_cnt;
    cpu_op(0, 32'h1006_0010, 0); chk("miss", 32'h1006_0010, q);
    cpu_op(0, 32'h1006_0018, 0); chk("hit", 32'h1006_0018, q);
    chk("hit fills", n0 + 1, rd_cnt);
  endtask
  task automatic t_pass;
    n0 = rd_cnt;
    cpu_op(0, 32'h0000_2004, 0); chk("outside", 32'h0000_2004, q);
    cpu_instr_i <= 1'b1;
    cpu_op(0, 32'h1006_0018, 0); chk("fetch", n0 + 2, rd_cnt);
    cpu_instr_i <= 1'b0;
    reg_op(1, REG_CTRL, 32'h0000_0004);
    cpu_op(0, 32'h1006_0014, 0); chk("bypass", n0 + 3, rd_cnt);
    reg_op(1, REG_CTRL, 32'h0000_0000);
  endtask
  task automatic t_merge_drain;
    int n;
    cpu_op(1, 32'h1006_0104, 32'hAABB_CCDD);
    cpu_op(0, 32'h1006_0104, 0); chk("merge wr", 32'hAABB_CCDD, q);
    cpu_op(0, 32'h1006_0108, 0); chk("merge rd", 32'h1006_0108, q);
    n0 = wr_cnt;
    reg_op(1, REG_CTRL, 32'h0000_0002);
    n = 0;
    do reg_op(0, REG_STATUS, 0); while (q[0] !== 1'b1 && ++n < 40);
    chk("drain done", 1, q[0]);
    chk("drain cnt", n0 + 1, wr_cnt);
    chk("drain addr", 32'h1006_0100, waddr);
    chk("drain bytes", 32'h0000_00F0, {16'h0, wstrb});
    n0 = rd_cnt;
    cpu_op(0, 32'h1006_0104, 0); chk("kept", 32'hAABB_CCDD, q);
    chk("kept hit", n0, rd_cnt);
  endtask
  task automatic t_discard_age;
    n0 = rd_cnt;
    reg_op(1, REG_CTRL, 32'h0000_0001);
    cpu_op(0, 32'h1006_0018, 0); chk("discard", n0 + 1, rd_cnt);
    reg_op(1, REG_CFG, 32'h0008_0020);
    cpu_op(0, 32'h1006_0018, 0); chk("fresh", n0 + 1, rd_cnt);
    repeat (80) @(posedge mclk_i);
    cpu_op(0, 32'h1006_0018, 0); chk("aged", n0 + 2, rd_cnt);
  endtask
  task automatic wrap_up;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    t_regs();
    t_read();
    t_pass();
    t_merge_drain();
    t_discard_age();
    wrap_up();
  end
endmodule // data_line_buffer_bridge_bench
`default_nettype wire

// *** testbench/data_line_buffer_bridge_props.sv ***
`timescale 1ns/1ps
`default_nettype none
// port-level checks of the line buffer bridge
module data_line_buffer_bridge_props
  import line_buffer_pkg::*;
#(parameter int NUM_LINES = 32) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic cpu_req_i,
  input wire logic cpu_we_i,
  input wire logic cpu_instr_i,
  input wire logic [31:0] cpu_addr_i,
  input wire logic cpu_ready_o,
  input wire logic mem_req_o,
  input wire logic mem_we_o,
  input wire logic [31:0] mem_addr_o,
  input wire logic [15:0] mem_wstrb_o,
  input wire logic mem_ack_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_re_i,
  input wire logic [31:0] reg_rdata_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  a_mem_hold: assert property (mem_req_o && !mem_ack_i |=> mem_req_o
    && $stable(mem_addr_o) && $stable(mem_we_o)) else $error("mem hold");
  a_mem_release: assert property (mem_req_o && mem_ack_i |=> !mem_req_o)
    else $error("mem req kept after ack");
  a_fill_answer: assert property (mem_req_o && mem_ack_i && !mem_we_o
    |=> cpu_ready_o) else $error("no ready after fill");
  a_read_wait: assert property (mem_req_o && !mem_we_o |-> !cpu_ready_o)
    else $error("ready during read");
  a_ready_pulse: assert property (cpu_ready_o |=> !cpu_ready_o)
    else $error("ready longer than one cycle");
  a_window_pass: assert property ($rose(mem_req_o) && !mem_we_o && cpu_req_i
    && cpu_addr_i < WIN_LO |-> mem_addr_o == cpu_addr_i)
    else $error("outside access not passed through");
  a_fetch_pass: assert property ($rose(mem_req_o) && !mem_we_o && cpu_req_i
    && cpu_instr_i |-> mem_addr_o == cpu_addr_i) else $error("fetch buffered");
  a_flush_bytes: assert property (mem_req_o && mem_we_o
    |-> mem_wstrb_o != 16'h0000) else $error("write without bytes");
  a_ctrl_pulse: assert property (reg_re_i && reg_addr_i == REG_CTRL
    |=> reg_rdata_o[1:0] == 2'b00) else $error("command bits stick");
  a_reset_quiet: assert property (disable iff (1'b0) sys_rst_i
    |=> !mem_req_o && !cpu_ready_o) else $error("activity in reset");
  c_flush: cover property (mem_req_o && mem_ack_i && mem_we_o);
  c_fill: cover property (mem_req_o && mem_ack_i && !mem_we_o);
  c_write: cover property (cpu_ready_o && cpu_we_i);
endmodule // data_line_buffer_bridge_props
bind data_line_buffer_bridge data_line_buffer_bridge_props #(
  .NUM_LINES(NUM_LINES)) props_inst (.mclk_i, .sys_rst_i, .cpu_req_i,
  .cpu_we_i, .cpu_instr_i, .cpu_addr_i, .cpu_ready_o, .mem_req_o, .mem_we_o,
  .mem_addr_o, .mem_wstrb_o, .mem_ack_i, .reg_addr_i, .reg_re_i,
  .reg_rdata_o);
`default_nettype wire

// *** testbench/line_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// far-side memory: answers prompt and slow in turn, counts transfers
module line_mem_model (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic mem_req_i,
  input wire logic mem_we_i,
  input wire logic [31:0] mem_addr_i,
  input wire logic [15:0] mem_wstrb_i,
  output logic mem_ack_o,
  output logic [127:0] mem_rdata_o,
  output int rd_cnt_o,
  output int wr_cnt_o,
  output logic [31:0] waddr_o,
  output logic [15:0] wstrb_o
);
  logic [31:0] la; // line-aligned address
  int wait_q; // cycles spent on the current request
  logic slow_q; // next answer is the slow one
  assign la = {mem_addr_i[31:4], 4'h0};
  // each word reads back its own byte address; idle data toggles
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      mem_ack_o <= 1'b0;
      mem_rdata_o <= '0;
      {rd_cnt_o, wr_cnt_o, wait_q} <= '0;
      {slow_q, waddr_o, wstrb_o} <= '0;
    end else if (mem_req_i && !mem_ack_o && wait_q >= (slow_q ? 4 : 0)) begin
      mem_ack_o <= 1'b1;
      wait_q <= 0;
      slow_q <= !slow_q;
      mem_rdata_o <= {la + 32'hC, la + 32'h8, la + 32'h4, la};
      if (mem_we_i) begin
        wr_cnt_o <= wr_cnt_o + 1;
        waddr_o <= mem_addr_i;
        wstrb_o <= mem_wstrb_i;
      end else begin
        rd_cnt_o <= rd_cnt_o + 1;
      end
    end else begin
      mem_ack_o <= 1'b0;
      mem_rdata_o <= ~mem_rdata_o;
      if (mem_req_i && !mem_ack_o) begin
        wait_q <= wait_q + 1;
      end
    end
  end
endmodule // line_mem_model
`default_nettype wire
